// ### pkg/bissm_regs.svh
// offsets, field positions, reset values and timing counts of the master
// assumes a byte-wide host port and a 125 MHz core clock
`ifndef BISSM_REGS_SVH
`define BISSM_REGS_SVH
`define BM_OFF_DLEN 5'h00
`define BM_OFF_CHK 5'h01
`define BM_OFF_FREQ 5'h02
`define BM_OFF_CFW 5'h04
`define BM_OFF_CFW_TOP 5'h07
`define BM_OFF_POSH 5'h08
`define BM_OFF_POSL 5'h0C
`define BM_OFF_CRES 5'h10
`define BM_OFF_CERR 5'h14
`define BM_OFF_STAT 5'h16
`define BM_OFF_PCRC 5'h18
`define BM_OFF_CCRC 5'h19
`define BM_OFF_RAW 5'h1A
`define BM_OFF_PROC 5'h1C
`define BM_OFF_LDLY 5'h1E
`define BM_ST_AVG 0
`define BM_ST_OVR 1
`define BM_ST_CMD 2
`define BM_ST_PCRC 3
`define BM_ST_CCRC 4
`define BM_ST_NOSLV 5
`define BM_ST_EMG 6
`define BM_FQ_1 8'h01
`define BM_FQ_2 8'h02
`define BM_FQ_5 8'h05
`define BM_FQ_10 8'h0A
`define BM_D0_1M 5'h17
`define BM_D1_1M 5'h02
`define BM_D0_2M 5'h17
`define BM_D1_2M 5'h00
`define BM_D0_5M 5'h08
`define BM_D1_5M 5'h00
`define BM_D0_10M 5'h03
`define BM_D1_10M 5'h00
`define BM_PCRC_TAPS 6'h03
`define BM_CCRC_TAPS 4'h3
`define BM_PCRC_BITS 6
`define BM_DLEN_RST 8'h1A
`define BM_CHK_RST 8'h08
`define BM_CDM_ZEROS 4'hE
`define BM_PROC_LIMIT 16'h0100
`define BM_ACK_LIMIT 8'h40
`define BM_PHASE_K 20'h66666
`define BM_CLK_MHZ 125
`define BM_FRAME_NS 100000
`define BM_FRAME_CYC (`BM_FRAME_NS * `BM_CLK_MHZ / 1000)
`define BM_TOUT_NS 20000
`define BM_TOUT_CYC (`BM_TOUT_NS * `BM_CLK_MHZ / 1000)
`endif

// ### pkg/bissm_pkg.sv
// types used by the encoder master; its sample window buffer declares its own
// assumes nothing beyond a SystemVerilog compiler
package bissm_pkg;
	typedef enum logic [2:0] {
		IDLE, ACKW, PROCW, BITS, TOUT, AVG
	} bissm_state_e;
	typedef struct packed {
		logic we;
		logic re;
		logic [4:0] addr;
		logic [7:0] wdata;
	} bissm_host_s;
	typedef struct packed {
		bissm_state_e st;
		logic slo1, slo2, slo3, emg1, emg2;
		logic [15:0] acc;
		logic tick;
		logic [2:0] ph, sph;
		logic [27:0] sr;
		logic [7:0] dlen, chk, freq;
		logic [4:0] first_sample_divider, second_sample_divider;
		logic [15:0] inc;
		logic [31:0] cfw, cfs, cshift, cres;
		logic cf_pend, cf_act, cdm, good, ma, rvalid;
		logic [5:0] cf_cnt;
		logic [3:0] zeros;
		logic [63:0] pos;
		logic [31:0] pos_hi, pos_lo, avg;
		logic [15:0] cerr, proc, pcnt;
		logic [7:0] stat, nstat, pcrc, ccrc, raw, ldly, wait_n, rdata;
		logic [5:0] rx_crc, crc;
		logic [8:0] bitn;
		logic [13:0] timer;
		logic [33:0] sum;
	} bissm_st_s;
endpackage

// ### verilog/bissm_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module bissm_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out,
	output logic [$clog2(D):0] count_out
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp, rp;
		logic [AW:0] cnt;
	} bissm_fifo_s;
	bissm_fifo_s s_r, s_nxt;
	logic push, pop;

	assign in_ready_out = (s_r.cnt != (AW+1)'(D));
	assign out_valid_out = (s_r.cnt != '0);
	assign out_data_out = s_r.mem[s_r.rp];
	assign count_out = s_r.cnt;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_ready_in && out_valid_out;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_in;
			s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ### verilog/bissm_master.sv
// point-to-point encoder link master with byte-addressed host memory
// assumes the data line arrives from a transceiver, unsynchronised
`timescale 1ns/1ps
`include "bissm_regs.svh"
module bissm_master #(
	parameter int FRAME_CYCLES = `BM_FRAME_CYC
) (
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic HOST_WE_IN,
	input wire logic HOST_RE_IN,
	input wire logic [4:0] HOST_ADDR_IN,
	input wire logic [7:0] HOST_WDATA_IN,
	output logic [7:0] HOST_RDATA_OUT,
	output logic HOST_RVALID_OUT,
	input wire logic BISS_SLO_IN,
	input wire logic EMERGENCY_TEST_IN,
	output logic BISS_MA_OUT,
	output logic [4:0] SAMPLE_DIV_FIRST_OUT,
	output logic [4:0] SAMPLE_DIV_SECOND_OUT,
	output logic [31:0] AVG_POSITION_OUT
);
	localparam logic [13:0] TOUT_LAST = 14'(`BM_TOUT_CYC - 1);
	localparam logic [13:0] FRAME_LAST = 14'(FRAME_CYCLES - 1);
	localparam logic [15:0] INC_RST = 16'(`BM_PHASE_K /
		((`BM_D0_1M + 2) * (`BM_D1_1M + 2)));
	bissm_pkg::bissm_st_s s_r, s_nxt;
	bissm_pkg::bissm_host_s h;
	logic f_in_valid, f_in_ready, f_out_ready;
	logic [31:0] f_out;
	logic [2:0] f_cnt;

	function automatic logic [9:0] div_of(input logic [7:0] f);
		unique case (f)
			`BM_FQ_2: div_of = {`BM_D0_2M, `BM_D1_2M};
			`BM_FQ_5: div_of = {`BM_D0_5M, `BM_D1_5M};
			`BM_FQ_10: div_of = {`BM_D0_10M, `BM_D1_10M};
			default: div_of = {`BM_D0_1M, `BM_D1_1M};
		endcase
	endfunction

	// phase step per core clock: divisor code c means c+2
	function automatic logic [15:0] inc_of(input logic [4:0] d0,
			input logic [4:0] d1);
		logic [11:0] p;
		logic [19:0] q;
		p = 12'(({1'b0, d0} + 6'h02) * ({1'b0, d1} + 6'h02));
		q = `BM_PHASE_K / {8'h00, p};
		inc_of = q[15:0];
	endfunction

	function automatic logic legal_freq(input logic [7:0] f);
		legal_freq = (f == `BM_FQ_1) || (f == `BM_FQ_2) ||
			(f == `BM_FQ_5) || (f == `BM_FQ_10);
	endfunction

	function automatic logic [5:0] crc6_step(input logic [5:0] c,
			input logic b);
		crc6_step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? `BM_PCRC_TAPS : 6'h00);
	endfunction

	function automatic logic [3:0] crc4_of(input logic [27:0] d);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 27; i >= 0; i--) begin
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? `BM_CCRC_TAPS : 4'h0);
		end
		crc4_of = c;
	endfunction

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	function automatic logic [31:0] word_of(input bissm_pkg::bissm_st_s s,
			input logic [2:0] w);
		unique case (w)
			3'h2: word_of = s.pos_hi;
			3'h3: word_of = s.pos_lo;
			3'h4: word_of = s.cres;
			3'h5: word_of = {8'h00, s.stat, s.cerr};
			3'h6: word_of = {8'h00, s.raw, s.ccrc, s.pcrc};
			3'h7: word_of = {8'h00, s.ldly, s.proc};
			default: word_of = 32'h0000_0000;
		endcase
	endfunction

	assign h = '{we: HOST_WE_IN, re: HOST_RE_IN, addr: HOST_ADDR_IN,
		wdata: HOST_WDATA_IN};
	assign f_in_valid = (s_r.st == bissm_pkg::AVG) && s_r.good;
	assign f_out_ready = (s_r.st == bissm_pkg::AVG) && s_r.good &&
		!f_in_ready;

	bissm_fifo #(.W(32), .D(4)) u_window (
		.clk_in(CORE_CLK_IN),
		.arst_n_in(ARST_N_IN),
		.in_valid_in(f_in_valid),
		.in_ready_out(f_in_ready),
		.in_data_in(s_r.pos_lo),
		.out_valid_out(),
		.out_ready_in(f_out_ready),
		.out_data_out(f_out),
		.count_out(f_cnt)
	);

	always_comb begin
		logic b;
		logic [31:0] w;
		logic [8:0] tot, crc_from;
		b = maj3(s_r.sr[2:0]);
		w = 32'h0000_0000;
		tot = {1'b0, s_r.dlen} + {1'b0, s_r.chk} + 9'h001;
		crc_from = {1'b0, s_r.dlen} + {1'b0, s_r.chk} - 9'h005;
		s_nxt = s_r;
		// pin inputs pass two flops; core grid is the timing resolution
		s_nxt.slo1 = BISS_SLO_IN;
		s_nxt.slo2 = s_r.slo1;
		s_nxt.emg1 = EMERGENCY_TEST_IN;
		s_nxt.emg2 = s_r.emg1;
		{s_nxt.tick, s_nxt.acc} = {1'b0, s_r.acc} + {1'b0, s_r.inc};
		if (s_r.tick) begin
			s_nxt.sr = {s_r.sr[26:0], s_r.slo2};
			s_nxt.slo3 = s_r.slo2;
		end
		// host side of the shared structure
		s_nxt.rvalid = h.re;
		w = word_of(s_r, h.addr[4:2]);
		s_nxt.rdata = 8'(w >> {h.addr[1:0], 3'b000});
		if (h.we) begin
			unique case (h.addr)
				`BM_OFF_DLEN: s_nxt.dlen = h.wdata;
				`BM_OFF_CHK: s_nxt.chk = h.wdata;
				`BM_OFF_FREQ: begin
					if (legal_freq(h.wdata)) begin
						s_nxt.freq = h.wdata;
					end
				end
				5'h04, 5'h05, 5'h06, 5'h07: begin
					s_nxt.cfw[{h.addr[1:0], 3'b000} +: 8] = h.wdata;
					if (h.addr == `BM_OFF_CFW_TOP) begin
						s_nxt.cf_pend = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (s_r.tick && s_r.st inside {bissm_pkg::ACKW,
				bissm_pkg::PROCW, bissm_pkg::BITS}) begin
			s_nxt.ph = s_r.ph + 3'h1;
			s_nxt.ma = s_nxt.ph[2];
		end
		unique case (s_r.st)
			bissm_pkg::IDLE: begin
				s_nxt.ma = 1'b1;
				s_nxt.timer = s_r.timer + 14'h0001;
				if (s_r.timer >= FRAME_LAST) begin
					// rate taken at each frame start
					{s_nxt.first_sample_divider, s_nxt.second_sample_divider} = div_of(s_r.freq);
					s_nxt.inc = inc_of(s_nxt.first_sample_divider, s_nxt.second_sample_divider);
					s_nxt.acc = 16'h0000;
					s_nxt.tick = 1'b0;
					s_nxt.ph = 3'h0;
					s_nxt.ma = 1'b0;
					s_nxt.timer = 14'h0000;
					s_nxt.nstat = 8'h00;
					s_nxt.bitn = 9'h000;
					s_nxt.wait_n = 8'h00;
					s_nxt.ldly = 8'h00;
					s_nxt.pcnt = 16'h0000;
					s_nxt.pos = 64'h0000_0000_0000_0000;
					s_nxt.crc = 6'h00;
					s_nxt.good = 1'b0;
					s_nxt.st = bissm_pkg::ACKW;
					if (s_r.zeros != 4'h0) begin
						s_nxt.cdm = 1'b0;
						s_nxt.zeros = s_r.zeros - 4'h1;
					end else if (s_r.cf_act) begin
						s_nxt.cdm = s_r.cfs[31];
						s_nxt.cfs = {s_r.cfs[30:0], 1'b0};
					end else if (s_r.cf_pend) begin
						s_nxt.cf_act = 1'b1;
						s_nxt.cf_pend = 1'b0;
						s_nxt.cf_cnt = 6'h20;
						s_nxt.cdm = s_r.cfw[31];
						s_nxt.cfs = {s_r.cfw[30:0], 1'b0};
						s_nxt.nstat[`BM_ST_CMD] = 1'b1;
					end else begin
						s_nxt.cdm = 1'b0;
					end
					if (!s_r.slo2) begin
						s_nxt.nstat[`BM_ST_NOSLV] = 1'b1;
						s_nxt.st = bissm_pkg::TOUT;
					end
				end
			end
			bissm_pkg::ACKW: begin
				if (s_r.tick) begin
					if (s_r.ldly != 8'hFF) begin
						s_nxt.ldly = s_r.ldly + 8'h01;
					end
					if (!s_r.slo2) begin
						s_nxt.st = bissm_pkg::PROCW;
					end else if (s_r.ph == 3'h7) begin
						s_nxt.wait_n = s_r.wait_n + 8'h01;
						if (s_nxt.wait_n == `BM_ACK_LIMIT) begin
							s_nxt.nstat[`BM_ST_NOSLV] = 1'b1;
							s_nxt.st = bissm_pkg::TOUT;
						end
					end
				end
			end
			bissm_pkg::PROCW: begin
				if (s_r.tick) begin
					if (s_r.slo2 && !s_r.slo3) begin
						s_nxt.sph = s_r.ph + 3'h4;
						s_nxt.raw = s_nxt.sr[7:0];
						// next sample is the start bit itself
						s_nxt.bitn = 9'h1FF;
						s_nxt.proc = s_r.pcnt;
						s_nxt.st = bissm_pkg::BITS;
					end else if (s_r.ph == 3'h7) begin
						// keep clocking through the slave's delay
						s_nxt.pcnt = s_r.pcnt + 16'h0001;
						if (s_nxt.pcnt >= `BM_PROC_LIMIT) begin
							s_nxt.proc = s_nxt.pcnt;
							s_nxt.nstat[`BM_ST_OVR] = 1'b1;
							s_nxt.st = bissm_pkg::TOUT;
						end
					end
				end
			end
			bissm_pkg::BITS: begin
				if (s_r.tick && s_r.ph == s_r.sph) begin
					// vote of the middle samples
					s_nxt.bitn = s_r.bitn + 9'h001;
					if (s_r.bitn == 9'h1FF) begin
						// start bit, nothing kept
					end else if (s_r.bitn == 9'h000) begin
						s_nxt.cshift = {s_r.cshift[30:0], b};
					end else if (s_r.bitn <= {1'b0, s_r.dlen}) begin
						s_nxt.pos = {s_r.pos[62:0], b};
						s_nxt.crc = crc6_step(s_r.crc, b);
					end else if (s_r.bitn < crc_from) begin
						s_nxt.crc = crc6_step(s_r.crc, b);
					end else begin
						s_nxt.rx_crc = {s_r.rx_crc[4:0], b};
					end
					if (s_nxt.bitn == tot) begin
						s_nxt.good = 1'b1;
						s_nxt.pos_hi = s_nxt.pos[63:32];
						s_nxt.pos_lo = s_nxt.pos[31:0];
						s_nxt.pcrc = {2'b00, s_nxt.rx_crc};
						if (s_nxt.rx_crc != ~s_r.crc) begin
							s_nxt.nstat[`BM_ST_PCRC] = 1'b1;
							if (s_r.cerr != 16'hFFFF) begin
								s_nxt.cerr = s_r.cerr + 16'h0001;
							end
						end
						if (s_r.cf_act) begin
							s_nxt.cf_cnt = s_r.cf_cnt - 6'h01;
							if (s_r.cf_cnt == 6'h01) begin
								s_nxt.cf_act = 1'b0;
								s_nxt.zeros = `BM_CDM_ZEROS;
								s_nxt.cres = s_nxt.cshift;
								s_nxt.ccrc = {4'h0, s_nxt.cshift[3:0]};
								if (crc4_of(s_nxt.cshift[31:4]) !=
										~s_nxt.cshift[3:0]) begin
									s_nxt.nstat[`BM_ST_CCRC] = 1'b1;
								end
							end
						end
						s_nxt.timer = 14'h0000;
						s_nxt.st = bissm_pkg::TOUT;
					end
				end
			end
			bissm_pkg::TOUT: begin
				// line held at the inverted control bit until timeout
				s_nxt.ma = !s_r.cdm;
				s_nxt.timer = s_r.timer + 14'h0001;
				if (s_r.timer >= TOUT_LAST) begin
					s_nxt.ma = 1'b1;
					s_nxt.timer = 14'h0000;
					s_nxt.st = bissm_pkg::AVG;
				end
			end
			bissm_pkg::AVG: begin
				s_nxt.ma = 1'b1;
				s_nxt.timer = s_r.timer + 14'h0001;
				if (!s_r.good) begin
					s_nxt.stat = s_r.nstat;
					s_nxt.stat[`BM_ST_EMG] = s_r.emg2;
					s_nxt.st = bissm_pkg::IDLE;
				end else if (!f_in_ready) begin
					s_nxt.sum = s_r.sum - {2'b00, f_out};
				end else begin
					s_nxt.sum = s_r.sum + {2'b00, s_r.pos_lo};
					s_nxt.avg = s_nxt.sum[33:2];
					// whole frame result replaces the status
					s_nxt.stat = s_r.nstat;
					s_nxt.stat[`BM_ST_AVG] = (f_cnt == 3'h3);
					s_nxt.stat[`BM_ST_EMG] = s_r.emg2;
					s_nxt.st = bissm_pkg::IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s_r <= '0;
			s_r.dlen <= `BM_DLEN_RST;
			s_r.chk <= `BM_CHK_RST;
			s_r.freq <= `BM_FQ_1;
			s_r.first_sample_divider <= `BM_D0_1M;
			s_r.second_sample_divider <= `BM_D1_1M;
			s_r.inc <= INC_RST;
			s_r.zeros <= `BM_CDM_ZEROS;
			s_r.ma <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign HOST_RDATA_OUT = s_r.rdata;
	assign HOST_RVALID_OUT = s_r.rvalid;
	assign BISS_MA_OUT = s_r.ma;
	assign SAMPLE_DIV_FIRST_OUT = s_r.first_sample_divider;
	assign SAMPLE_DIV_SECOND_OUT = s_r.second_sample_divider;
	assign AVG_POSITION_OUT = s_r.avg;

	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	sequence frame_start;
		s_r.st == bissm_pkg::IDLE ##1 s_r.st == bissm_pkg::ACKW;
	endsequence

	a_freq_legal: assert property (legal_freq(s_r.freq))
		else $error("link frequency code left the legal set");
	a_freq_reject: assert property (
		h.we && h.addr == `BM_OFF_FREQ &&
		!legal_freq(h.wdata) |=> $stable(s_r.freq))
		else $error("illegal frequency code was taken");
	a_div_ten: assert property (frame_start ##0
		$past(s_r.freq) == `BM_FQ_10 |-> s_r.first_sample_divider == 5'h03 &&
		s_r.second_sample_divider == 5'h00)
		else $error("wrong dividers for 10 MHz");
	a_start_low: assert property (frame_start |-> !s_r.ma)
		else $error("frame did not open with a falling clock");
	a_sr_shift: assert property (s_r.tick |=>
		s_r.sr[0] == $past(s_r.slo2))
		else $error("sample not shifted into bit 0");
	a_sample_mid: assert property (
		$past(s_r.st) == bissm_pkg::PROCW &&
		s_r.st == bissm_pkg::BITS |-> s_r.sph == $past(s_r.ph) + 3'h4)
		else $error("sample point not placed mid-bit");
	a_cerr_step: assert property (
		s_r.cerr == $past(s_r.cerr) ||
		s_r.cerr == $past(s_r.cerr) + 16'h0001)
		else $error("error count moved by other than one");
	a_stat_top: assert property (!s_r.stat[7])
		else $error("unused status bit set");
	a_proc_wait: assert property (s_r.st == bissm_pkg::PROCW &&
		s_r.slo2 && s_r.slo3 |=> s_r.st != bissm_pkg::IDLE)
		else $error("frame dropped while slave was busy");
endmodule

// ### verification/bissm_slave_model.sv
// behavioural encoder slave answering the link clock of the master
// assumes the clock line idles high and a frame begins on its first fall
`timescale 1ns/1ps
module bissm_slave_model #(
	parameter int DLY_NS = 30
) (
	input wire logic ma_in,
	input wire logic present_in,
	input wire logic bad_crc_in,
	input wire logic [63:0] pos_in,
	input wire logic [7:0] dlen_in,
	input wire logic [7:0] ew_in,
	input wire logic [15:0] ack_extra_in,
	output logic slo_out
);
	int n_r;
	bit busy_r;
	realtime last_r;

	// msb first, seed zero, x^6+x+1
	function automatic logic [5:0] crc6(logic [63:0] d, int n);
		logic [5:0] c;
		logic fb;
		c = 6'h00;
		for (int i = n - 1; i >= 0; i--) begin
			fb = c[5] ^ d[i];
			c = {c[4:0], 1'b0};
			if (fb) begin
				c = c ^ 6'h03;
			end
		end
		return c;
	endfunction

	initial begin
		slo_out = 1'b1;
		busy_r = 0;
		n_r = 0;
		last_r = 0;
	end

	always @(posedge ma_in or negedge ma_in) begin
		last_r = $realtime;
	end

	always @(negedge ma_in) begin
		if (!busy_r) begin
			busy_r = 1;
			n_r = 0;
		end
	end

	// ack, delayed start, cds, data and warning bits, inverted check
	always @(posedge ma_in) begin
		int k;
		int nb;
		logic [63:0] d;
		logic [5:0] c;
		logic v;
		nb = int'(dlen_in) + int'(ew_in);
		d = (pos_in << ew_in) | ((64'h1 << ew_in) - 64'h1);
		c = ~crc6(d, nb) ^ {5'h00, bad_crc_in};
		if (busy_r) begin
			n_r++;
			k = n_r - 2 - int'(ack_extra_in);
			if (k < 0) begin
				v = 1'b0;
			end else if (k == 0) begin
				v = 1'b1;
			end else if (k == 1) begin
				v = 1'b0;
			end else if (k < nb + 2) begin
				v = d[nb + 1 - k];
			end else if (k < nb + 8) begin
				v = c[nb + 7 - k];
			end else begin
				v = 1'b0;
			end
			slo_out <= #DLY_NS (present_in ? v : 1'b0);
		end
	end

	// end of frame once the clock has stood still, line back to ready
	always #100 begin
		if (busy_r && ($realtime - last_r > 5000.0)) begin
			busy_r = 0;
		end
		if (!busy_r) begin
			slo_out <= present_in;
		end
	end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the encoder master through its host byte port and its divider and average outputs
// assumes the slave model above and a shortened idle time between frames
`timescale 1ns/1ps
`include "bissm_regs.svh"
module tb_top;
	localparam int FRAME_CYC = 1000;
	localparam int CEIL = 90000;
	logic clk, arst_n, we, re, rvalid, slo, emg, ma;
	logic [4:0] addr, first_sample_divider, second_sample_divider;
	logic [7:0] wdata, rdata;
	logic [31:0] avg, v;
	logic present, bad_crc;
	logic [63:0] pos;
	logic [15:0] ack_extra;
	logic [7:0] fq [3] = '{8'h05, 8'h02, 8'h0A};
	logic [9:0] dv [3] = '{10'h100, 10'h2E0, 10'h060};
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;

	bissm_master #(.FRAME_CYCLES(FRAME_CYC)) bissm_master_i (
		.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .HOST_WE_IN(we),
		.HOST_RE_IN(re), .HOST_ADDR_IN(addr), .HOST_WDATA_IN(wdata),
		.HOST_RDATA_OUT(rdata), .HOST_RVALID_OUT(rvalid),
		.BISS_SLO_IN(slo), .EMERGENCY_TEST_IN(emg), .BISS_MA_OUT(ma),
		.SAMPLE_DIV_FIRST_OUT(first_sample_divider), .SAMPLE_DIV_SECOND_OUT(second_sample_divider),
		.AVG_POSITION_OUT(avg)
	);

	bissm_slave_model bissm_slave_model_i (
		.ma_in(ma), .present_in(present), .bad_crc_in(bad_crc),
		.pos_in(pos), .dlen_in(8'h28), .ew_in(8'h02),
		.ack_extra_in(ack_extra), .slo_out(slo)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		we = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		we = 1'b0;
	endtask

	// little-endian multi-byte read, answer taken one cycle later
	task automatic rd(input logic [4:0] a, input int n,
		output logic [31:0] r);
		r = 32'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			re = 1'b1;
			addr = a + i[4:0];
			@(posedge clk);
			#1;
			re = 1'b0;
			check("read_valid", 32'h1, {31'h0, rvalid});
			r[8*i +: 8] = rdata;
		end
	endtask

	task automatic chkr(input string what, input logic [4:0] a, input int n,
		input logic [31:0] exp);
		logic [31:0] r;
		rd(a, n, r);
		check(what, exp, r);
	endtask

	// one frame seen or 3000 cycles passed without one, then the line idle long enough for its results
	task automatic wait_frame();
		int hi;
		int n;
		bit seen;
		hi = 0;
		n = 0;
		seen = 0;
		while (!(hi >= 2700 && (seen || n >= 3000))) begin
			@(posedge clk);
			n++;
			if (ma === 1'b0) begin
				seen = 1;
				hi = 0;
			end else begin
				hi++;
			end
		end
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == CEIL) begin
			check("timeout", 32'h0, 32'h1);
			close_out();
		end
	end

	initial begin
		arst_n = 1'b0;
		we = 1'b0;
		re = 1'b0;
		addr = 5'h00;
		wdata = 8'h00;
		emg = 1'b0;
		present = 1'b1;
		bad_crc = 1'b0;
		pos = 64'h0000_00A5_1234_5678;
		ack_extra = 16'h0000;
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		check("div_pair", 32'h2E2, {22'h0, first_sample_divider, second_sample_divider});
		check("average", 32'h0, avg);
		chkr("unused_byte", 5'h17, 1, 32'h0);
		chkr("write_only", `BM_OFF_DLEN, 1, 32'h0);
		wr(`BM_OFF_DLEN, 8'h28);
		wr(`BM_OFF_CHK, 8'h08);
		wr(`BM_OFF_FREQ, 8'h03);
		wait_frame();
		check("div_pair", 32'h2E2, {22'h0, first_sample_divider, second_sample_divider});
		chkr("pos_upper", `BM_OFF_POSH, 4, 32'hA5);
		chkr("pos_lower", `BM_OFF_POSL, 4, 32'h1234_5678);
		chkr("status", `BM_OFF_STAT, 1, 32'h00);
		chkr("crc_fails", `BM_OFF_CERR, 2, 32'h0);
		rd(`BM_OFF_RAW, 1, v);
		check("raw_mixed", 32'h1, {31'h0, v != 0 && v != 32'hFF});
		for (int i = 0; i < 3; i++) begin
			wr(`BM_OFF_FREQ, fq[i]);
			wait_frame();
			check("div_pair", {22'h0, dv[i]}, {22'h0, first_sample_divider, second_sample_divider});
		end
		chkr("status", `BM_OFF_STAT, 1, 32'h01);
		check("average", 32'h1234_5678, avg);
		bad_crc = 1'b1;
		wait_frame();
		rd(`BM_OFF_STAT, 1, v);
		check("status", 32'h08, v & 32'hFE);
		chkr("crc_fails", `BM_OFF_CERR, 2, 32'h1);
		bad_crc = 1'b0;
		pos = 64'h0000_00C3_8765_4321;
		ack_extra = 16'd300;
		wait_frame();
		rd(`BM_OFF_STAT, 1, v);
		check("status", 32'h02, v & 32'hFE);
		chkr("pos_lower", `BM_OFF_POSL, 4, 32'h1234_5678);
		ack_extra = 16'd20;
		emg = 1'b1;
		wait_frame();
		rd(`BM_OFF_STAT, 1, v);
		check("status", 32'h40, v & 32'hFE);
		chkr("pos_lower", `BM_OFF_POSL, 4, 32'h8765_4321);
		chkr("pos_upper", `BM_OFF_POSH, 4, 32'hC3);
		chkr("crc_fails", `BM_OFF_CERR, 2, 32'h1);
		present = 1'b0;
		emg = 1'b0;
		wait_frame();
		rd(`BM_OFF_STAT, 1, v);
		check("status", 32'h20, v & 32'hFE);
		close_out();
	end
endmodule
